/* File: hw/sixteen_bit_timer_counter.sv */
/*
 * 16-bit timer/counter with APB register access, prescaler, internal
 * or external count clock, overflow interrupt and trigger clear.
 * Assumes an APB master on i_mclk, a trigger pulse from the
 * capture_compare_unit on the same clock, and an external count pin
 * that is asynchronous and slower than a quarter of i_mclk.
 */
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ns
module sixteen_bit_timer_counter
    import timer_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [DATA_W-1:0] i_pwdata,
    output logic [DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_external_count_input,
    input wire logic i_special_event,
    output logic o_irq,
    output logic o_low_power_osc_enable
);
    logic [BYTE_W-1:0] control_r;
    logic [COUNT_W-1:0] count_r;
    logic [COUNT_W-1:0] count_nxt;
    logic [BYTE_W-1:0] high_buf_r;
    logic [BYTE_W-1:0] high_buf_nxt;
    logic [BYTE_W-1:0] status_r;
    logic [BYTE_W-1:0] status_nxt;
    logic [BYTE_W-1:0] mask_r;
    logic [PHASE_W-1:0] phase_r;
    logic [PRE_W-1:0] pre_r;
    logic ext_last_r;
    logic ext_pend_r;
    logic [DATA_W-1:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic irq_r;
    logic ext_level;

    // Bus decode
    wire setup = i_psel & ~i_penable;
    wire access_done = i_psel & i_penable & pready_r;
    wire wr_acc = access_done & i_pwrite;
    wire sel_ctrl = (i_paddr == OFS_CONTROL);
    wire sel_lo = (i_paddr == OFS_COUNT_LOW);
    wire sel_hi = (i_paddr == OFS_COUNT_HIGH);
    wire sel_stat = (i_paddr == OFS_IRQ_STATUS);
    wire sel_mask = (i_paddr == OFS_IRQ_MASK);
    wire addr_hit = sel_ctrl | sel_lo | sel_hi | sel_stat | sel_mask;
    wire [BYTE_W-1:0] wbyte = i_pwdata[BYTE_W-1:0];
    wire wr_ctrl = wr_acc & sel_ctrl;
    wire wr_lo = wr_acc & sel_lo;
    wire wr_hi = wr_acc & sel_hi;
    wire wr_stat = wr_acc & sel_stat;
    wire wr_mask = wr_acc & sel_mask;
    wire rd_lo_setup = setup & ~i_pwrite & sel_lo;

    // Control fields
    wire wide = control_r[WIDE_BIT];
    wire [1:0] ps_sel = control_r[PS_HI_BIT:PS_LO_BIT];
    wire sync_n = control_r[SYNC_N_BIT];
    wire src_ext = control_r[SRC_BIT];
    wire run = control_r[RUN_BIT];

    // Count halves, as software sees them
    wire [BYTE_W-1:0] count_hi = count_r[COUNT_W-1:BYTE_W];
    wire [BYTE_W-1:0] count_lo = count_r[BYTE_W-1:0];

    // Read view; high byte comes from the buffer in wide mode
    wire [BYTE_W-1:0] hi_view = wide ? high_buf_r : count_hi;
    wire [BYTE_W-1:0] rd_byte =
        sel_ctrl ? (control_r & CONTROL_WMASK) :
        sel_lo ? count_lo :
        sel_hi ? hi_view :
        sel_stat ? status_r :
        sel_mask ? mask_r : BYTE_ZERO;

    // Count clock sources
    pin_sync ext_sync (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_pin(i_external_count_input),
        .o_level(ext_level)
    );

    wire inst_tick = (phase_r == PHASE_LAST);
    wire ext_edge = ext_level & ~ext_last_r;
    // Synchronised mode lines edges up with the internal phase
    wire ext_tick = sync_n ? ext_edge :
        (inst_tick & (ext_edge | ext_pend_r));
    wire src_tick = src_ext ? ext_tick : inst_tick;

    wire [PRE_W-1:0] pre_mask =
        (ps_sel == PS_DIV8) ? PRE_MASK8 :
        (ps_sel == PS_DIV4) ? PRE_MASK4 :
        (ps_sel == PS_DIV2) ? PRE_MASK2 : PRE_MASK1;
    wire pre_full = ((pre_r & pre_mask) == pre_mask);
    wire cnt_inc = run & src_tick & pre_full;

    wire count_write = wr_lo | (wr_hi & ~wide);
    // A count write or trigger in the same cycle overrides the wrap
    wire wrap = cnt_inc & (count_r == COUNT_MAX) & ~i_special_event &
        ~count_write;

    // Trigger clear beats software write, which beats increment
    always_comb begin
        count_nxt = count_r;
        if (i_special_event) begin
            count_nxt = COUNT_ZERO;
        end else if (wr_lo) begin
            count_nxt = wide ? {high_buf_r, wbyte} :
                {count_hi, wbyte};
        end else if (wr_hi & ~wide) begin
            count_nxt = {wbyte, count_lo};
        end else if (cnt_inc) begin
            count_nxt = count_r + COUNT_STEP;
        end
    end

    // Buffer feeds the wide high read and the wide low write
    always_comb begin
        high_buf_nxt = high_buf_r;
        if (rd_lo_setup & wide) begin
            high_buf_nxt = count_hi;
        end else if (wr_hi & wide) begin
            high_buf_nxt = wbyte;
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_comb begin
        status_nxt = status_r;
        if (wr_stat) begin
            status_nxt = status_r & ~(wbyte & IRQ_WMASK);
        end
        if (wrap) begin
            status_nxt[OVF_BIT] = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            control_r <= CONTROL_RESET;
        end else if (wr_ctrl) begin
            control_r <= wbyte & CONTROL_WMASK;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            count_r <= COUNT_ZERO;
            high_buf_r <= BYTE_ZERO;
        end else begin
            count_r <= count_nxt;
            high_buf_r <= high_buf_nxt;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            status_r <= IRQ_RESET;
            mask_r <= IRQ_RESET;
        end else begin
            status_r <= status_nxt;
            if (wr_mask) begin
                mask_r <= wbyte & IRQ_WMASK;
            end
        end
    end

    // Phase runs freely so the internal rate does not drift with run
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            phase_r <= PHASE_RESET;
        end else begin
            phase_r <= phase_r + PHASE_STEP;
        end
    end

    // Prescaler restarts on any count write, as in a reload
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pre_r <= PRE_RESET;
        end else if (count_write | i_special_event) begin
            pre_r <= PRE_RESET;
        end else if (run & src_tick) begin
            pre_r <= pre_full ? PRE_RESET : pre_r + PRE_STEP;
        end
    end

    // Pending edge waits for the next internal tick in synced mode
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_last_r <= 1'b0;
            ext_pend_r <= 1'b0;
        end else begin
            ext_last_r <= ext_level;
            ext_pend_r <= (ext_edge | ext_pend_r) & ~inst_tick;
        end
    end

    // Zero-wait APB: data is captured in setup, ready in access
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            prdata_r <= {UPPER_ZERO, BYTE_ZERO};
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & ~addr_hit;
            if (setup) begin
                prdata_r <= {UPPER_ZERO, rd_byte};
            end
        end
    end

    // Built from the next status so the line rises with the flag
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_nxt & mask_r);
        end
    end

    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_irq = irq_r;
    // Oscillator enable drives the pad cell directly
    assign o_low_power_osc_enable = control_r[OSC_BIT];

    default clocking dflt_cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    a_ctrl_bit6_zero: assert property (
        setup & ~i_pwrite & sel_ctrl |=> !o_prdata[UNUSED_BIT])
        else $error("control bit 6 read back as one");

    a_wrap_sets_flag: assert property (
        wrap |=> status_r[OVF_BIT] && count_r == COUNT_ZERO)
        else $error("wrap did not set overflow flag");

    a_flag_sticky: assert property (
        status_r[OVF_BIT] && !wr_stat |=> status_r[OVF_BIT])
        else $error("overflow flag dropped without a clear");

    a_trigger_clears: assert property (
        i_special_event |=> count_r == COUNT_ZERO)
        else $error("trigger did not clear the count");

    a_stop_holds: assert property (
        !run && !count_write && !i_special_event |=> $stable(count_r))
        else $error("count moved while stopped");

    a_internal_rate: assert property (
        cnt_inc && !src_ext |=> !cnt_inc [*3])
        else $error("internal clock faster than a quarter rate");

    a_pin_ignored: assert property (
        !src_ext && !inst_tick |-> !cnt_inc)
        else $error("internal source counted off its tick");

    a_sync_on_phase: assert property (
        src_ext && !sync_n && cnt_inc |-> inst_tick)
        else $error("synchronised count off the internal tick");

    a_unsync_on_edge: assert property (
        src_ext && sync_n && cnt_inc |-> ext_edge)
        else $error("unsynchronised count without a pin edge");

    a_div8_prescale: assert property (
        cnt_inc && ps_sel == PS_DIV8 |-> pre_r == PRE_MASK8)
        else $error("divide-by-8 tick on wrong prescale count");

    a_wide_hi_read: assert property (
        setup && !i_pwrite && sel_hi && wide |=>
            o_prdata[BYTE_W-1:0] == $past(high_buf_r))
        else $error("wide high read not from buffer");

    a_low_latch: assert property (
        rd_lo_setup && wide |=> high_buf_r == $past(count_hi))
        else $error("low read did not latch high byte");

    a_wide_hi_write: assert property (
        wr_hi && wide |=> high_buf_r == $past(wbyte))
        else $error("wide high write missed the buffer");

    a_wide_low_load: assert property (
        wr_lo && wide && !i_special_event |=>
            count_r == {$past(high_buf_r), $past(wbyte)})
        else $error("wide low write did not load both bytes");

    a_byte_hi_write: assert property (
        wr_hi && !wide && !i_special_event |=> count_hi == $past(wbyte))
        else $error("byte mode high write did not land");

    a_irq_level: assert property (
        status_r[OVF_BIT] && mask_r[OVF_BIT] |=>
            o_irq || !status_r[OVF_BIT])
        else $error("interrupt not raised for masked-in flag");

    a_run_step: assert property (
        cnt_inc && !count_write && !i_special_event |=>
            count_r == $past(count_r) + COUNT_STEP)
        else $error("running count did not advance by one");

    a_trig_prescale: assert property (
        i_special_event |=> pre_r == PRE_RESET)
        else $error("trigger did not restart the prescaler");

    a_pready_single: assert property (
        o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");

    a_unmapped_err: assert property (
        setup && !addr_hit |=> o_pslverr && o_pready)
        else $error("unmapped access not flagged");

    c_wrap: cover property (wrap);
    c_trigger: cover property (i_special_event && run);
    c_wide_read: cover property (rd_lo_setup && wide);
    c_ext_count: cover property (cnt_inc && src_ext);
    c_sync_ext: cover property (cnt_inc && src_ext && !sync_n);
endmodule

/* File: hw/timer_pkg.sv */
/*
 * Constants shared by the 16-bit timer/counter: register offsets,
 * control field positions, reset values and prescale encodings.
 * Assumes an APB master with an 8-bit byte address and 32-bit data.
 */
package timer_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int COUNT_W = 16;
    localparam int PRE_W = 3;
    localparam int PHASE_W = 2;

    // Byte addresses, one aligned word each
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_COUNT_LOW = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;

    // timer_control fields
    localparam int WIDE_BIT = 7;
    localparam int UNUSED_BIT = 6;
    localparam int PS_HI_BIT = 5;
    localparam int PS_LO_BIT = 4;
    localparam int OSC_BIT = 3;
    localparam int SYNC_N_BIT = 2;
    localparam int SRC_BIT = 1;
    localparam int RUN_BIT = 0;

    localparam logic [BYTE_W-1:0] CONTROL_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] CONTROL_WMASK = 8'hBF;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [23:0] UPPER_ZERO = 24'h000000;

    // Interrupt status / mask layout
    localparam int OVF_BIT = 0;
    localparam logic [BYTE_W-1:0] IRQ_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] IRQ_WMASK = 8'h01;

    // Internal count clock is the master clock divided by four
    localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 2'h0;
    localparam logic [PHASE_W-1:0] PHASE_STEP = 2'h1;

    // prescale_select codes and matching divider masks
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV2 = 2'h1;
    localparam logic [1:0] PS_DIV4 = 2'h2;
    localparam logic [1:0] PS_DIV8 = 2'h3;
    localparam logic [PRE_W-1:0] PRE_MASK1 = 3'h0;
    localparam logic [PRE_W-1:0] PRE_MASK2 = 3'h1;
    localparam logic [PRE_W-1:0] PRE_MASK4 = 3'h3;
    localparam logic [PRE_W-1:0] PRE_MASK8 = 3'h7;
    localparam logic [PRE_W-1:0] PRE_RESET = 3'h0;
    localparam logic [PRE_W-1:0] PRE_STEP = 3'h1;

    localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_STEP = 16'h0001;

endpackage

/* File: hw/pin_sync.sv */
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes the input is asynchronous to i_mclk; the output changes only
 * once the second and third stages agree.
 */
`timescale 1ns/1ns
module pin_sync (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_pin,
    output logic o_level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    // First stage is seen only by the second
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            level_r <= 1'b0;
        end else if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end

    assign o_level = level_r;
endmodule

/* File: sim/ext_clock_source.sv */
/*
 * Behavioural external count clock feeding the timer's count pin.
 * Assumes the bench calls send() from one thread at a time.
 */
`timescale 1ns/1ns
module ext_clock_source (
    input wire logic i_mclk,
    output logic o_pin
);
    initial o_pin = 1'b0;
    // Stands low between bursts, like a gated source
    task automatic send(input int n, input int half);
        repeat (n) begin
            @(posedge i_mclk);
            o_pin <= 1'b1;
            repeat (half) @(posedge i_mclk);
            o_pin <= 1'b0;
            repeat (half) @(posedge i_mclk);
        end
    endtask
endmodule

/* File: sim/sixteen_bit_timer_counter_tb.sv */
/*
 * Self-checking bench for the 16-bit timer/counter: APB master tasks,
 * a small integer model of the count and an external clock model.
 * Assumes the design answers each APB access within a few cycles.
 */
`timescale 1ns/1ns
module sixteen_bit_timer_counter_tb import timer_pkg::*;;
    logic i_mclk, i_nrst, psel, penable, pwrite, trig, err;
    logic pready, pslverr, irq, osc_en, ext_pin;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [7:0] seed;
    logic [15:0] m_count;
    int failures, tests_run, cycles;

    ext_clock_source ext_u (.i_mclk(i_mclk), .o_pin(ext_pin));
    sixteen_bit_timer_counter dut_u (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_external_count_input(ext_pin),
        .i_special_event(trig), .o_irq(irq),
        .o_low_power_osc_enable(osc_en)
    );

    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 2200 cycles the tests need
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            final_report();
        end
    end

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge i_mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        // Only the bench timeout ends a hung access
        do begin
            @(posedge i_mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string name);
        apb(1'b0, a, 32'h00000000);
        check(name, e, rd);
    endtask

    // Byte mode only: each write lands directly
    task automatic set_count(input logic [15:0] v);
        apb(1'b1, OFS_COUNT_LOW, {24'h000000, v[7:0]});
        apb(1'b1, OFS_COUNT_HIGH, {24'h000000, v[15:8]});
        m_count = v;
    endtask

    task automatic chk_count;
        rchk(OFS_COUNT_LOW, {24'h000000, m_count[7:0]}, "count low");
        rchk(OFS_COUNT_HIGH, {24'h000000, m_count[15:8]}, "count high");
    endtask

    task automatic ctl(input logic [7:0] v);
        apb(1'b1, OFS_CONTROL, {24'h000000, v});
    endtask

    initial begin
        logic [7:0] c;
        int n;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        trig = 1'b0;
        i_nrst = 1'b0;
        seed = 8'h5D;
        failures = 0;
        tests_run = 0;
        cycles = 0;
        repeat (12) @(posedge i_mclk);
        i_nrst <= 1'b1;
        for (int a = 0; a <= 16; a += 4) begin
            rchk(a[7:0], 32'h00000000, "reset value");
        end
        check("osc enable", 32'h0, {31'h0, osc_en});
        apb(1'b0, 8'h14, 32'h00000000);
        check("unmapped err", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        $display("reset test done");
        repeat (6) begin
            seed = lfsr(seed);
            c = (seed & 8'hFE) | 8'h40;
            ctl(c);
            rchk(OFS_CONTROL, {24'h0, c & 8'hBF}, "control");
            check("osc enable", 32'(c[OSC_BIT]), 32'(osc_en));
        end
        $display("control test done");
        ctl(8'h00);
        seed = lfsr(seed);
        c = lfsr(seed);
        set_count({c, seed});
        chk_count();
        ctl(8'h80);
        apb(1'b1, OFS_COUNT_HIGH, 32'h00000012);
        ctl(8'h00);
        chk_count();
        ctl(8'h80);
        apb(1'b1, OFS_COUNT_LOW, 32'h00000034);
        m_count = 16'h1234;
        rchk(OFS_COUNT_LOW, 32'h00000034, "wide low");
        @(posedge i_mclk);
        trig <= 1'b1;
        @(posedge i_mclk);
        trig <= 1'b0;
        rchk(OFS_COUNT_HIGH, 32'h00000012, "wide high");
        ctl(8'h00);
        m_count = 16'h0000;
        chk_count();
        $display("access mode test done");
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 4; p++) begin
                c = {2'b00, p[1:0], 1'b0, s[0], 2'b10};
                ctl(c);
                set_count(16'h0000);
                ctl(c | 8'h01);
                seed = lfsr(seed);
                n = 8 + seed[3:0];
                ext_u.send(n, 6);
                // Let the pin synchroniser drain
                repeat (8) @(posedge i_mclk);
                ctl(c);
                m_count = 16'(n >> p);
                chk_count();
            end
        end
        ext_u.send(5, 6);
        chk_count();
        $display("external clock test done");
        for (int s = 0; s < 2; s++) begin
            ctl(8'h00);
            set_count(16'h0000);
            ctl({5'h00, s[0], 2'b01});
            // Pin activity must not count on the internal source
            fork
                ext_u.send(10, 2);
                repeat (80) @(posedge i_mclk);
            join
            ctl(8'h00);
            apb(1'b0, OFS_COUNT_LOW, 32'h00000000);
            n = int'(rd >= 32'd19 && rd <= 32'd22);
            check("internal range", 32'h1, 32'(n));
        end
        $display("internal clock test done");
        apb(1'b1, OFS_IRQ_MASK, 32'h00000000);
        ctl(8'h06);
        set_count(16'hFFFE);
        ctl(8'h07);
        ext_u.send(2, 6);
        repeat (8) @(posedge i_mclk);
        ctl(8'h06);
        m_count = 16'h0000;
        chk_count();
        rchk(OFS_IRQ_STATUS, 32'h00000001, "status");
        check("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_IRQ_MASK, 32'h00000001);
        repeat (3) @(posedge i_mclk);
        check("irq", 32'h1, {31'h0, irq});
        rchk(OFS_IRQ_STATUS, 32'h00000001, "sticky");
        apb(1'b1, OFS_IRQ_STATUS, 32'h00000001);
        repeat (3) @(posedge i_mclk);
        check("irq cleared", 32'h0, {31'h0, irq});
        rchk(OFS_IRQ_STATUS, 32'h00000000, "status cleared");
        $display("overflow test done");
        final_report();
    end
endmodule
